// >>> hw/mies_core.sv
// Execute stage for a subset of an 8-bit controller instruction set, with a Wishbone view of its state.
// Assumes the fetch side presents a decoded instruction and the operand byte read combinationally at
// op_mem_addr_in, and that the return stack presents its top entry on stack_top_in.
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
module mies_core #(
  parameter int ADDR_W = 10,
  parameter int PC_W   = 12
) (
  // Clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        reset_in,
  // Decoded instruction issue
  input  wire logic                        op_valid_in,
  input  wire mies_pkg::mies_op_type       op_code_in,
  input  wire logic [ADDR_W-1:0]           op_mem_addr_in,
  input  wire logic [7:0]                  op_imm_in,
  input  wire logic [2:0]                  op_bit_in,
  input  wire logic [PC_W-1:0]             op_target_in,
  output logic                             op_ready_out,
  // Data memory
  input  wire logic [7:0]                  mem_rdata_in,
  output logic                             mem_we_out,
  output logic      [ADDR_W-1:0]           mem_waddr_out,
  output logic      [7:0]                  mem_wdata_out,
  // Return stack
  input  wire logic [PC_W-1:0]             stack_top_in,
  output logic                             stack_pop_out,
  // Visible state
  output logic      [PC_W-1:0]             pc_out,
  output logic      [7:0]                  acc_out,
  output logic      [3:0]                  status_out,
  output logic                             master_interrupt_enable_out,
  output logic                             dummy_cycle_out,
  // Wishbone slave
  input  wire logic                        wb_cyc_in,
  input  wire logic                        wb_stb_in,
  input  wire logic                        wb_we_in,
  input  wire logic [3:0]                  wb_adr_in,
  input  wire logic [3:0]                  wb_sel_in,
  input  wire logic [31:0]                 wb_dat_in,
  output logic      [31:0]                 wb_dat_out,
  output logic                             wb_ack_out
);

  if (ADDR_W < 1 || ADDR_W > 16 || PC_W < 2 || PC_W > 16) begin : g_bad_width
    $error("mies_core: ADDR_W must be 1..16 and PC_W 2..16");
  end

  mies_pkg::mies_state_type state_q;
  logic [PC_W-1:0]          pc_q;
  logic [7:0]               acc_q;
  logic [3:0]               flags_q;
  logic                     mie_q;
  logic                     mem_we_q;
  logic [ADDR_W-1:0]        mem_waddr_q;
  logic [7:0]               mem_wdata_q;
  logic                     ack_q;
  logic [31:0]              rdata_q;

  logic       taken;
  logic       is_jump;
  logic       is_return;
  logic [7:0] alu_res;
  logic       alu_acc_we;
  logic       alu_mem_we;
  logic [3:0] alu_flags;
  logic       alu_skip;
  logic       bus_req;
  logic       bus_wr;

  mies_alu u_alu (
    .op_in      (op_code_in),
    .acc_in     (acc_q),
    .mem_in     (mem_rdata_in),
    .imm_in     (op_imm_in),
    .bit_in     (op_bit_in),
    .flags_in   (flags_q),
    .res_out    (alu_res),
    .acc_we_out (alu_acc_we),
    .mem_we_out (alu_mem_we),
    .flags_out  (alu_flags),
    .skip_out   (alu_skip)
  );

  // The dummy slot holds off issue for exactly one cycle
  assign op_ready_out = (state_q == mies_pkg::st_execute);
  assign taken        = op_valid_in && op_ready_out;
  assign is_jump      = (op_code_in == mies_pkg::op_jump);
  assign is_return    = (op_code_in == mies_pkg::op_return) ||
                        (op_code_in == mies_pkg::op_return_with_imm) ||
                        (op_code_in == mies_pkg::op_return_from_interrupt_op);
  assign stack_pop_out = taken && is_return;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_q <= mies_pkg::st_execute;
    end else if (taken && (is_jump || is_return || alu_skip)) begin
      state_q <= mies_pkg::st_dummy;
    end else begin
      state_q <= mies_pkg::st_execute;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pc_q <= '0;
    end else if (taken) begin
      if (is_jump) begin
        pc_q <= op_target_in;
      end else if (is_return) begin
        pc_q <= stack_top_in;
      end else if (alu_skip) begin
        pc_q <= pc_q + PC_W'(mies_pkg::SKIP_STEP);
      end else begin
        pc_q <= pc_q + PC_W'(mies_pkg::PC_STEP);
      end
    end
  end

  // Bus transfers are taken once, on the edge that raises ack
  assign bus_req = wb_cyc_in && wb_stb_in && !ack_q;
  assign bus_wr  = bus_req && wb_we_in && wb_sel_in[0];

  // accumulator update; an issuing instruction beats a bus write
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      acc_q <= mies_pkg::ACC_RESET;
    end else if (taken && alu_acc_we) begin
      acc_q <= alu_res;
    end else if (!taken && bus_wr && wb_adr_in == mies_pkg::OFS_ACC) begin
      acc_q <= wb_dat_in[7:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      flags_q <= mies_pkg::FLAGS_RESET;
    end else if (taken) begin
      flags_q <= alu_flags;
    end else if (bus_wr && wb_adr_in == mies_pkg::OFS_STATUS) begin
      flags_q <= wb_dat_in[mies_pkg::FLAG_W-1:0];
    end
  end

  // enable set wins over bus clear
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mie_q <= mies_pkg::MIE_RESET;
    end else if (taken && op_code_in == mies_pkg::op_return_from_interrupt_op) begin
      mie_q <= 1'b1;
    end else if (bus_wr && wb_adr_in == mies_pkg::OFS_CTRL) begin
      mie_q <= wb_dat_in[mies_pkg::CTRL_MIE];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mem_we_q    <= 1'b0;
      mem_waddr_q <= '0;
      mem_wdata_q <= mies_pkg::BYTE_ZERO;
    end else begin
      mem_we_q <= taken && alu_mem_we;
      if (taken && alu_mem_we) begin
        mem_waddr_q <= op_mem_addr_in;
        mem_wdata_q <= alu_res;
      end
    end
  end

  // Wishbone answer one cycle after the request; unmapped offsets read zero
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        case (wb_adr_in)
          mies_pkg::OFS_ACC:    rdata_q <= {24'h00_0000, acc_q};
          mies_pkg::OFS_STATUS: rdata_q <= {28'h000_0000, flags_q};
          mies_pkg::OFS_CTRL:   rdata_q <= {31'h0000_0000, mie_q};
          mies_pkg::OFS_PC:     rdata_q <= 32'(pc_q);
          default:              rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign pc_out                      = pc_q;
  assign acc_out                     = acc_q;
  assign status_out                  = flags_q;
  assign master_interrupt_enable_out = mie_q;
  assign dummy_cycle_out             = (state_q == mies_pkg::st_dummy);
  assign mem_we_out                  = mem_we_q;
  assign mem_waddr_out               = mem_waddr_q;
  assign mem_wdata_out               = mem_wdata_q;
  assign wb_ack_out                  = ack_q;
  assign wb_dat_out                  = rdata_q;

  // Checks on the executed results
  property p_inc_acc;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_increment_to_accumulator) |=>
      (acc_q == $past(mem_rdata_in) + 8'h01) && !mem_we_out;
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment result not in accumulator");

  property p_jump;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && is_jump) |=> (pc_q == $past(op_target_in)) && !op_ready_out ##1 op_ready_out;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or timing wrong");

  property p_move_flags;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && (op_code_in == mies_pkg::op_move_mem_to_acc || op_code_in == mies_pkg::op_move_imm_to_acc ||
               op_code_in == mies_pkg::op_move_acc_to_mem)) |=> $stable(flags_q);
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("move changed flags");

  property p_nop;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_nop) |=>
      $stable(acc_q) && $stable(flags_q) && !mem_we_out && pc_q == $past(pc_q) + 1'b1;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");

  property p_or_zero;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_or_to_accumulator) |=>
      flags_q[mies_pkg::FLAG_Z] == (acc_q == 8'h00) && flags_q[mies_pkg::FLAG_C] == $past(flags_q[mies_pkg::FLAG_C]);
  endproperty
  a_or_zero: assert property (p_or_zero) else $error("OR zero flag wrong");

  property p_return;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && is_return) |-> stack_pop_out ##1 (pc_q == $past(stack_top_in)) && $stable(flags_q);
  endproperty
  a_return: assert property (p_return) else $error("return did not restore address");

  property p_return_from_interrupt_op;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_return_from_interrupt_op) |=> master_interrupt_enable_out;
  endproperty
  a_return_from_interrupt_op: assert property (p_return_from_interrupt_op) else $error("interrupt enable not set");

  property p_sub_carry;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_subtract_with_borrow) |=>
      flags_q[mies_pkg::FLAG_C] == ($past({1'b0, acc_q}) >= $past({1'b0, mem_rdata_in}) + $past(9'(!flags_q[0])));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

  property p_skip_two;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && alu_skip) |=> dummy_cycle_out && pc_q == $past(pc_q) + 2'd2 ##1 op_ready_out;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip did not take two cycles");

  property p_noskip_one;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && !alu_skip && (op_code_in == mies_pkg::op_decrement_skip_if_zero ||
                            op_code_in == mies_pkg::op_increment_skip_if_zero)) |=> op_ready_out;
  endproperty
  a_noskip_one: assert property (p_noskip_one) else $error("untaken skip stalled");

  property p_set_byte;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_set_byte) |=>
      mem_we_out && mem_wdata_out == 8'hff && mem_waddr_out == $past(op_mem_addr_in) ##1 !mem_we_out || op_valid_in;
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("byte set write wrong");

  property p_ret_imm;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_return_with_imm) |=>
      acc_q == $past(op_imm_in) &&
      $stable(flags_q);
  endproperty
  a_ret_imm: assert property (p_ret_imm) else $error("return did not load immediate");

  property p_rot_left;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_rotate_left_to_accumulator) |=>
      acc_q == $past({mem_rdata_in[6:0], mem_rdata_in[7]}) &&
      $stable(flags_q) && !mem_we_out;
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("left rotate wrong");

  property p_rot_carry;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_rotate_right_carry_to_accumulator) |=>
      acc_q == $past({flags_q[mies_pkg::FLAG_C], mem_rdata_in[7:1]}) &&
      flags_q[mies_pkg::FLAG_C] == $past(mem_rdata_in[0]);
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("carry rotate wrong");

  property p_dec_skip;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_decrement_skip_if_zero) |=>
      mem_we_out && mem_wdata_out == $past(mem_rdata_in) - 8'h01 &&
      mem_waddr_out == $past(op_mem_addr_in) && $stable(flags_q);
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement write wrong");

  property p_set_bit;
    @(posedge sys_clk_in) disable iff (reset_in)
    (taken && op_code_in == mies_pkg::op_set_bit) |=>
      mem_we_out && $stable(flags_q) &&
      mem_wdata_out == ($past(mem_rdata_in) | (8'h01 << $past(op_bit_in)));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set write wrong");

endmodule

// >>> hw/mies_pkg.sv
// Shared constants and types for the instruction execute subset.
// Assumes one system clock; every user includes nothing and names items as mies_pkg::name.
package mies_pkg;

  // Operand and flag widths
  localparam int DATA_W = 8;
  localparam int FLAG_W = 4;

  // Status flag positions
  localparam int FLAG_C   = 0;
  localparam int FLAG_AUX = 1;
  localparam int FLAG_Z   = 2;
  localparam int FLAG_OVF = 3;

  // Register byte offsets on the bus
  localparam logic [3:0] OFS_ACC    = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_CTRL   = 4'h8;
  localparam logic [3:0] OFS_PC     = 4'hc;
  localparam int         CTRL_MIE   = 0;

  // Reset values and data constants
  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic       MIE_RESET   = 1'b0;
  localparam logic [7:0] BYTE_ONES   = 8'hff;
  localparam logic [7:0] BYTE_ONE    = 8'h01;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // Program counter steps: plain advance and skip over one word
  localparam int PC_STEP   = 1;
  localparam int SKIP_STEP = 2;

  typedef enum logic [4:0] {
    op_nop                                = 5'h00,
    op_increment_to_accumulator           = 5'h01,
    op_jump                               = 5'h02,
    op_move_mem_to_acc                    = 5'h03,
    op_move_imm_to_acc                    = 5'h04,
    op_move_acc_to_mem                    = 5'h05,
    op_or_to_accumulator                  = 5'h06,
    op_or_imm_to_accumulator              = 5'h07,
    op_or_into_memory                     = 5'h08,
    op_return                             = 5'h09,
    op_return_with_imm                    = 5'h0a,
    op_return_from_interrupt_op           = 5'h0b,
    op_rotate_left_memory                 = 5'h0c,
    op_rotate_left_to_accumulator         = 5'h0d,
    op_rotate_left_through_carry          = 5'h0e,
    op_rotate_left_carry_to_accumulator   = 5'h0f,
    op_rotate_right_memory                = 5'h10,
    op_rotate_right_to_accumulator        = 5'h11,
    op_rotate_right_through_carry         = 5'h12,
    op_rotate_right_carry_to_accumulator  = 5'h13,
    op_subtract_with_borrow               = 5'h14,
    op_subtract_with_borrow_to_memory     = 5'h15,
    op_decrement_skip_if_zero             = 5'h16,
    op_decrement_skip_if_zero_to_accumulator = 5'h17,
    op_increment_skip_if_zero             = 5'h18,
    op_increment_skip_if_zero_to_accumulator = 5'h19,
    op_set_byte                           = 5'h1a,
    op_set_bit                            = 5'h1b
  } mies_op_type;

  // One-bit sequence state; the dummy slot follows two-cycle instructions
  typedef enum logic {
    st_execute = 1'b0,
    st_dummy   = 1'b1
  } mies_state_type;

endpackage

// >>> hw/mies_alu.sv
// Combinational datapath: result, write targets, new flags and skip decision.
// Assumes the operand byte and accumulator are stable for the issuing cycle.
`timescale 1ns/1ns
module mies_alu (
  // Instruction and operands
  input  wire mies_pkg::mies_op_type op_in,
  input  wire logic [7:0]            acc_in,
  input  wire logic [7:0]            mem_in,
  input  wire logic [7:0]            imm_in,
  input  wire logic [2:0]            bit_in,
  input  wire logic [3:0]            flags_in,
  // Results
  output logic      [7:0]            res_out,
  output logic                       acc_we_out,
  output logic                       mem_we_out,
  output logic      [3:0]            flags_out,
  output logic                       skip_out
);
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] inc;
  logic [7:0] dec;
  logic       c;

  assign c        = flags_in[mies_pkg::FLAG_C];
  assign inc      = mem_in + mies_pkg::BYTE_ONE;
  assign dec      = mem_in - mies_pkg::BYTE_ONE;
  // Borrow-in is the inverted carry
  assign diff     = {1'b0, acc_in} - {1'b0, mem_in} - {8'h00, ~c};
  assign low_diff = {1'b0, acc_in[3:0]} - {1'b0, mem_in[3:0]} - {4'h0, ~c};

  always_comb begin
    res_out    = mem_in;
    acc_we_out = 1'b0;
    mem_we_out = 1'b0;
    flags_out  = flags_in;
    skip_out   = 1'b0;
    case (op_in)
      mies_pkg::op_increment_to_accumulator: begin
        res_out    = inc;
        acc_we_out = 1'b1;
        flags_out[mies_pkg::FLAG_Z] = (inc == mies_pkg::BYTE_ZERO);
      end
      mies_pkg::op_move_mem_to_acc: acc_we_out = 1'b1;
      mies_pkg::op_move_imm_to_acc, mies_pkg::op_return_with_imm: begin
        res_out    = imm_in;
        acc_we_out = 1'b1;
      end
      mies_pkg::op_move_acc_to_mem: begin
        res_out    = acc_in;
        mem_we_out = 1'b1;
      end
      mies_pkg::op_or_to_accumulator, mies_pkg::op_or_into_memory: begin
        res_out    = acc_in | mem_in;
        acc_we_out = (op_in == mies_pkg::op_or_to_accumulator);
        mem_we_out = (op_in == mies_pkg::op_or_into_memory);
        flags_out[mies_pkg::FLAG_Z] = ((acc_in | mem_in) == mies_pkg::BYTE_ZERO);
      end
      mies_pkg::op_or_imm_to_accumulator: begin
        res_out    = acc_in | imm_in;
        acc_we_out = 1'b1;
        flags_out[mies_pkg::FLAG_Z] = ((acc_in | imm_in) == mies_pkg::BYTE_ZERO);
      end
      mies_pkg::op_rotate_left_memory, mies_pkg::op_rotate_left_to_accumulator: begin
        res_out    = {mem_in[6:0], mem_in[7]};
        acc_we_out = (op_in == mies_pkg::op_rotate_left_to_accumulator);
        mem_we_out = (op_in == mies_pkg::op_rotate_left_memory);
      end
      mies_pkg::op_rotate_right_memory, mies_pkg::op_rotate_right_to_accumulator: begin
        res_out    = {mem_in[0], mem_in[7:1]};
        acc_we_out = (op_in == mies_pkg::op_rotate_right_to_accumulator);
        mem_we_out = (op_in == mies_pkg::op_rotate_right_memory);
      end
      mies_pkg::op_rotate_left_through_carry, mies_pkg::op_rotate_left_carry_to_accumulator: begin
        res_out    = {mem_in[6:0], c};
        acc_we_out = (op_in == mies_pkg::op_rotate_left_carry_to_accumulator);
        mem_we_out = (op_in == mies_pkg::op_rotate_left_through_carry);
        flags_out[mies_pkg::FLAG_C] = mem_in[7];
      end
      mies_pkg::op_rotate_right_through_carry, mies_pkg::op_rotate_right_carry_to_accumulator: begin
        res_out    = {c, mem_in[7:1]};
        acc_we_out = (op_in == mies_pkg::op_rotate_right_carry_to_accumulator);
        mem_we_out = (op_in == mies_pkg::op_rotate_right_through_carry);
        flags_out[mies_pkg::FLAG_C] = mem_in[0];
      end
      mies_pkg::op_subtract_with_borrow, mies_pkg::op_subtract_with_borrow_to_memory: begin
        res_out    = diff[7:0];
        acc_we_out = (op_in == mies_pkg::op_subtract_with_borrow);
        mem_we_out = (op_in == mies_pkg::op_subtract_with_borrow_to_memory);
        flags_out[mies_pkg::FLAG_C]   = ~diff[8];
        flags_out[mies_pkg::FLAG_AUX] = ~low_diff[4];
        flags_out[mies_pkg::FLAG_Z]   = (diff[7:0] == mies_pkg::BYTE_ZERO);
        flags_out[mies_pkg::FLAG_OVF] = (acc_in[7] != mem_in[7]) && (diff[7] != acc_in[7]);
      end
      mies_pkg::op_decrement_skip_if_zero, mies_pkg::op_decrement_skip_if_zero_to_accumulator: begin
        res_out    = dec;
        acc_we_out = (op_in == mies_pkg::op_decrement_skip_if_zero_to_accumulator);
        mem_we_out = (op_in == mies_pkg::op_decrement_skip_if_zero);
        skip_out   = (dec == mies_pkg::BYTE_ZERO);
      end
      mies_pkg::op_increment_skip_if_zero, mies_pkg::op_increment_skip_if_zero_to_accumulator: begin
        res_out    = inc;
        acc_we_out = (op_in == mies_pkg::op_increment_skip_if_zero_to_accumulator);
        mem_we_out = (op_in == mies_pkg::op_increment_skip_if_zero);
        skip_out   = (inc == mies_pkg::BYTE_ZERO);
      end
      mies_pkg::op_set_byte: begin
        res_out    = mies_pkg::BYTE_ONES;
        mem_we_out = 1'b1;
      end
      mies_pkg::op_set_bit: begin
        res_out         = mem_in;
        res_out[bit_in] = 1'b1;
        mem_we_out      = 1'b1;
      end
      default: res_out = mem_in;
    endcase
  end
endmodule

// >>> tb/mies_mem_model.sv
// Behavioural data memory and return stack facing the execute stage.
// Assumes one clock; the bench pushes return addresses one cycle before a return is issued.
`timescale 1ns/1ns
module mies_mem_model #(
  parameter int ADDR_W = 10,
  parameter int PC_W   = 12
) (
  // Clock
  input  wire logic              sys_clk_in,
  // Memory side
  input  wire logic [ADDR_W-1:0] raddr_in,
  output logic      [7:0]        rdata_out,
  input  wire logic              we_in,
  input  wire logic [ADDR_W-1:0] waddr_in,
  input  wire logic [7:0]        wdata_in,
  // Stack side
  input  wire logic              push_in,
  input  wire logic [PC_W-1:0]   push_data_in,
  input  wire logic              pop_in,
  output logic      [PC_W-1:0]   top_out
);
  logic [7:0]      mem [2**ADDR_W];
  logic [PC_W-1:0] stk [8];
  int              sp = 0;
  initial for (int i = 0; i < 2**ADDR_W; i++) mem[i] = 8'(i * 37);
  assign rdata_out = mem[raddr_in];
  // An empty stack shows all ones, never a stale entry
  assign top_out = (sp > 0) ? stk[sp-1] : ~PC_W'(sp);
  always @(posedge sys_clk_in) begin
    if (we_in) mem[waddr_in] <= wdata_in;
    if (push_in) begin
      stk[sp] <= push_data_in;
      sp <= sp + 1;
    end else if (pop_in && sp > 0) sp <= sp - 1;
  end
endmodule

// >>> tb/mies_core_bench.sv
// Self-checking bench: random instructions against a reference, corner cases and bus accesses.
// Assumes mies_mem_model as the memory and return stack behind the core.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t got %h expected %h", $time, g, e); end end
module mies_core_bench;
  logic                  sys_clk_in = 1'b0, reset_in = 1'b1, op_valid_in = 1'b0, push_in = 1'b0;
  mies_pkg::mies_op_type op_code_in = mies_pkg::op_nop;
  logic [9:0]            op_mem_addr_in = 10'h000, mem_waddr_out;
  logic [7:0]            op_imm_in = 8'h00, mem_rdata_in, mem_wdata_out, acc_out, e_acc;
  logic [2:0]            op_bit_in = 3'h0;
  logic [11:0]           op_target_in = 12'h000, push_data_in = 12'h000, stack_top_in, pc_out, e_pc;
  logic                  wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, e_en;
  logic [3:0]            wb_adr_in = 4'h0, wb_sel_in = 4'hf, status_out, e_fl;
  logic [31:0]           wb_dat_in = 32'h0, wb_dat_out, q;
  logic                  op_ready_out, mem_we_out, stack_pop_out, master_interrupt_enable_out;
  logic                  dummy_cycle_out, wb_ack_out;
  logic [15:0]           cc [9] = '{16'h2001, 16'h2a00, 16'hb200, 16'hc200, 16'h20ff, 16'h2b00, 16'hc300,
                                    16'hcb00, 16'hba00};
  int                    seed, miscompares = 0, tests_run = 0;
  mies_core uut (.sys_clk_in, .reset_in, .op_valid_in, .op_code_in, .op_mem_addr_in, .op_imm_in, .op_bit_in,
    .op_target_in, .op_ready_out, .mem_rdata_in, .mem_we_out, .mem_waddr_out, .mem_wdata_out, .stack_top_in,
    .stack_pop_out, .pc_out, .acc_out, .status_out, .master_interrupt_enable_out, .dummy_cycle_out, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out);
  mies_mem_model mdl (.sys_clk_in, .raddr_in(op_mem_addr_in), .rdata_out(mem_rdata_in), .we_in(mem_we_out),
    .waddr_in(mem_waddr_out), .wdata_in(mem_wdata_out), .push_in, .push_data_in, .pop_in(stack_pop_out),
    .top_out(stack_top_in));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  function automatic void expect_op(input logic [4:0] op, input logic [7:0] m, input logic [7:0] imm,
      input logic [2:0] bt, input logic [11:0] tgt, output logic [7:0] nm, output logic two);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    logic [1:0] dst;
    logic       zu, sk, ov;
    {r, dst, zu, sk, nm, two} = {8'h00, 2'd0, 1'b0, 1'b0, m, 1'b0};
    d = {1'b0, e_acc} - {1'b0, m} - {8'h00, ~e_fl[0]};
    h = {1'b0, e_acc[3:0]} - {1'b0, m[3:0]} - {4'h0, ~e_fl[0]};
    ov = (e_acc[7] != m[7]) && (d[7] != e_acc[7]);
    e_pc = e_pc + 12'h001;
    case (op)
      5'h01: {r, dst, zu} = {m + 8'h01, 2'd1, 1'b1};
      5'h02, 5'h09, 5'h0a, 5'h0b: {e_pc, two} = {tgt, 1'b1};
      5'h03: {r, dst} = {m, 2'd1};
      5'h04: {r, dst} = {imm, 2'd1};
      5'h05: {r, dst} = {e_acc, 2'd2};
      5'h06: {r, dst, zu} = {e_acc | m, 2'd1, 1'b1};
      5'h07: {r, dst, zu} = {e_acc | imm, 2'd1, 1'b1};
      5'h08: {r, dst, zu} = {e_acc | m, 2'd2, 1'b1};
      5'h0c: {r, dst} = {m[6:0], m[7], 2'd2};
      5'h0d: {r, dst} = {m[6:0], m[7], 2'd1};
      5'h0e: {r, dst, e_fl[0]} = {m[6:0], e_fl[0], 2'd2, m[7]};
      5'h0f: {r, dst, e_fl[0]} = {m[6:0], e_fl[0], 2'd1, m[7]};
      5'h10: {r, dst} = {m[0], m[7:1], 2'd2};
      5'h11: {r, dst} = {m[0], m[7:1], 2'd1};
      5'h12: {r, dst, e_fl[0]} = {e_fl[0], m[7:1], 2'd2, m[0]};
      5'h13: {r, dst, e_fl[0]} = {e_fl[0], m[7:1], 2'd1, m[0]};
      5'h14: {r, dst, zu, e_fl[3], e_fl[1], e_fl[0]} = {d[7:0], 2'd1, 1'b1, ov, ~h[4], ~d[8]};
      5'h15: {r, dst, zu, e_fl[3], e_fl[1], e_fl[0]} = {d[7:0], 2'd2, 1'b1, ov, ~h[4], ~d[8]};
      5'h16: {r, dst, sk} = {m - 8'h01, 2'd2, 1'b1};
      5'h17: {r, dst, sk} = {m - 8'h01, 2'd1, 1'b1};
      5'h18: {r, dst, sk} = {m + 8'h01, 2'd2, 1'b1};
      5'h19: {r, dst, sk} = {m + 8'h01, 2'd1, 1'b1};
      5'h1a: {r, dst} = {8'hff, 2'd2};
      5'h1b: {r, dst} = {m | (8'h01 << bt), 2'd2};
      default: ;
    endcase
    if (op == 5'h0a) e_acc = imm;
    if (op == 5'h0b) e_en = 1'b1;
    if (dst == 2'd1) e_acc = r;
    if (dst == 2'd2) nm = r;
    if (zu) e_fl[2] = (r == 8'h00);
    if (sk && r == 8'h00) {two, e_pc} = {1'b1, e_pc + 12'h001};
  endfunction
  task automatic run_op(input logic [4:0] op, input logic [2:0] a, input logic [7:0] imm, input logic [2:0] bt,
      input logic [11:0] tgt);
    logic [7:0] nm;
    logic       two;
    logic       ret;
    ret = (op >= 5'h09 && op <= 5'h0b);
    @(posedge sys_clk_in);
    push_in <= ret;
    push_data_in <= tgt;
    @(posedge sys_clk_in);
    push_in <= 1'b0;
    op_valid_in <= 1'b1;
    op_code_in <= mies_pkg::mies_op_type'(op);
    op_mem_addr_in <= {7'h00, a};
    {op_imm_in, op_bit_in, op_target_in} <= {imm, bt, tgt};
    #5 `CHK(stack_pop_out, ret)
    expect_op(op, mdl.mem[a], imm, bt, tgt, nm, two);
    @(posedge sys_clk_in);
    op_valid_in <= 1'b0;
    #1 `CHK(acc_out, e_acc)
    `CHK(status_out, e_fl)
    `CHK(pc_out, e_pc)
    `CHK(master_interrupt_enable_out, e_en)
    `CHK(op_ready_out, ~two)
    `CHK(dummy_cycle_out, two)
    @(posedge sys_clk_in);
    #1 `CHK(mdl.mem[a], nm)
    `CHK(op_ready_out, 1'b1)
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d, output logic [31:0] rd);
    @(posedge sys_clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, we, adr, 24'h0, d};
    do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    seed = 32'hd4569232;
    {e_acc, e_fl, e_pc, e_en} = {8'h00, 4'h0, 12'h000, 1'b0};
    repeat (8) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    #1 `CHK({pc_out, acc_out, status_out, op_ready_out}, 25'h1)
    wb(1'b1, mies_pkg::OFS_ACC, 8'h3c, q);
    wb(1'b0, mies_pkg::OFS_ACC, 8'h00, q);
    `CHK(q, 32'h3c)
    wb(1'b1, mies_pkg::OFS_STATUS, 8'h05, q);
    wb(1'b0, mies_pkg::OFS_STATUS, 8'h00, q);
    `CHK(q, 32'h5)
    wb(1'b1, mies_pkg::OFS_PC, 8'h77, q);
    wb(1'b0, mies_pkg::OFS_PC, 8'h00, q);
    `CHK(q, 32'h0)
    wb(1'b1, mies_pkg::OFS_CTRL, 8'h01, q);
    wb(1'b0, mies_pkg::OFS_CTRL, 8'h00, q);
    `CHK(q, 32'h1)
    wb(1'b1, mies_pkg::OFS_CTRL, 8'h00, q);
    wb(1'b0, 4'h2, 8'h00, q);
    `CHK(q, 32'h0)
    {e_acc, e_fl} = {8'h3c, 4'h5};
    foreach (cc[i]) run_op(cc[i][15:11], cc[i][10:8], cc[i][7:0], 3'd0, 12'h000);
    repeat (400) run_op(5'($unsigned($random(seed)) % 28), 3'($random(seed)), 8'($random(seed)),
                        3'($random(seed)), 12'($random(seed)));
    tally_and_finish;
  end
endmodule
